// ==== core/lead_off_detect_control.sv ====
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// lead-off control register behind an APB slave
module lead_off_detect_control
    import lead_off_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [DATA_W-1:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    input wire logic CAL_DAC_ON_I,
    output logic [DATA_W-1:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic [NUM_ELEC-1:0] AC_ENABLE_O,
    output logic [NUM_ELEC-1:0] AC_PHASE_O,
    output logic [NUM_ELEC-1:0] DC_ENABLE_O,
    output logic [AC_LEVEL_W-1:0] AC_LEVEL_O,
    output logic [DC_LEVEL_W-1:0] DC_LEVEL_O
);
    logic [23:0] ctl_r, ctl_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic ready_r, ready_nxt;
    logic err_r, err_nxt;
    logic cal_meta_r, cal_sync_r;
    detect_cfg_type cfg;
    detect_cfg_type cfg_r;
    logic hit;
    logic setup;
    logic [23:0] strb_mask;

    // no wait state: answer in the access cycle after setup
    always_comb begin
        setup = PSEL_I && !PENABLE_I;
        hit = (PADDR_I == LEAD_OFF_CONTROL_ADDR);
        strb_mask = {{8{PSTRB_I[2]}}, {8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};
        ctl_nxt = ctl_r;
        rdata_nxt = rdata_r;
        ready_nxt = 1'b0;
        err_nxt = 1'b0;
        if (setup) begin
            ready_nxt = 1'b1;
            err_nxt = !hit; // unmapped addresses error, read zero
            rdata_nxt = '0;
            if (hit && !PWRITE_I) begin
                rdata_nxt = {8'h00, ctl_r & WRITE_MASK};
            end
        end
        // commit at completing edge only
        if (PSEL_I && PENABLE_I && ready_r && PWRITE_I && hit) begin
            ctl_nxt = ((PWDATA_I[23:0] & strb_mask) | (ctl_r & ~strb_mask))
                & WRITE_MASK;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctl_r <= LEAD_OFF_CONTROL_RESET;
            rdata_r <= '0;
            ready_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            ctl_r <= ctl_nxt;
            rdata_r <= rdata_nxt;
            ready_r <= ready_nxt;
            err_r <= err_nxt;
        end
    end

    // calibration DAC state may come from another domain, so synchronise
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cal_meta_r <= 1'b0;
            cal_sync_r <= 1'b0;
        end else begin
            cal_meta_r <= CAL_DAC_ON_I;
            cal_sync_r <= cal_meta_r;
        end
    end

    lead_off_decode u_decode (
        .reg_i(ctl_r),
        .cal_dac_on_i(cal_sync_r),
        .cfg_o(cfg)
    );

    // outputs registered; dc level forced to zero while unused
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cfg_r <= '0;
        end else begin
            cfg_r <= cfg;
        end
    end

    always_comb begin
        PRDATA_O = rdata_r;
        PREADY_O = ready_r;
        PSLVERR_O = err_r;
        AC_ENABLE_O = cfg_r.ac_enable;
        AC_PHASE_O = cfg_r.phase;
        DC_ENABLE_O = cfg_r.dc_enable;
        AC_LEVEL_O = cfg_r.ac_level;
        DC_LEVEL_O = cfg_r.dc_level_valid ? cfg_r.dc_level : '0;
    end
endmodule

// ==== core/lead_off_pkg.sv ====
// What this block does
// - bits 23:18 set per-electrode ac phase
// - bits 17:12 enable ac per electrode
// - ac enable is global select OR individual
// - global select skips the common electrode
// - bits 8:7 code ac excitation level
// - bits 4:2 code dc level, 10 nA steps
// - dc level used only when select is 0
// - enable low means no detection at all
// - enabled with select 0 gives dc detection
// - enabled with select 1: ac, no dc
// - calibration DAC on forces ac off
// - bit 0 master enable, bit 1 select
// - register at index 0x02, resets to zero
package lead_off_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int NUM_ELEC = 6;
    // register index as printed; byte address is four times it
    localparam logic [ADDR_W-1:0] LEAD_OFF_CONTROL_IDX = 8'h02;
    localparam logic [ADDR_W-1:0] LEAD_OFF_CONTROL_ADDR = 8'h08;
    localparam logic [23:0] LEAD_OFF_CONTROL_RESET = 24'h000000;
    // field positions
    localparam int PHASE_LSB = 18;
    localparam int AC_EN_LSB = 12;
    localparam int AC_LEVEL_LSB = 7;
    localparam int AC_LEVEL_W = 2;
    localparam int DC_LEVEL_LSB = 2;
    localparam int DC_LEVEL_W = 3;
    localparam int SELECT_BIT = 1;
    localparam int ENABLE_BIT = 0;
    // writable bits; reserved 11:9 and 6:5 stay zero
    localparam logic [23:0] WRITE_MASK = 24'hFFF19F;
    // electrode order within 6-bit vectors, msb first: LA LL RA V1 V2 CE
    localparam int CE_POS = 0;
    // dc step in nA
    localparam int DC_STEP_NA = 10;

    typedef struct packed {
        logic [NUM_ELEC-1:0] phase;
        logic [NUM_ELEC-1:0] ac_enable;
        logic [NUM_ELEC-1:0] dc_enable;
        logic [AC_LEVEL_W-1:0] ac_level;
        logic [DC_LEVEL_W-1:0] dc_level;
        logic dc_level_valid;
    } detect_cfg_type;
endpackage

// ==== core/lead_off_decode.sv ====
`timescale 1ns/1ps
// turns the stored register word into effective detection enables
module lead_off_decode
    import lead_off_pkg::*;
(
    input wire logic [23:0] reg_i,
    input wire logic cal_dac_on_i,
    output detect_cfg_type cfg_o
);
    logic lead_off_enable;
    logic global_ac_select;
    logic [NUM_ELEC-1:0] select_mask;

    // decode fields; select does not reach the common electrode
    always_comb begin
        lead_off_enable = reg_i[ENABLE_BIT];
        global_ac_select = reg_i[SELECT_BIT];
        select_mask = {NUM_ELEC{global_ac_select}};
        select_mask[CE_POS] = 1'b0;
        cfg_o.phase = reg_i[PHASE_LSB +: NUM_ELEC];
        cfg_o.ac_level = reg_i[AC_LEVEL_LSB +: AC_LEVEL_W];
        cfg_o.dc_level = reg_i[DC_LEVEL_LSB +: DC_LEVEL_W];
        // ac off when master off or calibration DAC running
        if (lead_off_enable && !cal_dac_on_i) begin
            cfg_o.ac_enable = select_mask | reg_i[AC_EN_LSB +: NUM_ELEC];
        end else begin
            cfg_o.ac_enable = '0;
        end
        // dc detection only while select is 0
        cfg_o.dc_enable = {NUM_ELEC{lead_off_enable && !global_ac_select}};
        cfg_o.dc_level_valid = lead_off_enable && !global_ac_select;
    end
endmodule

// ==== verif/lead_off_chk.sv ====
`timescale 1ns/1ps
module lead_off_chk
    import lead_off_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic PWRITE_I,
    input wire logic CAL_DAC_ON_I,
    input wire logic [DATA_W-1:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [NUM_ELEC-1:0] AC_ENABLE_O,
    input wire logic [NUM_ELEC-1:0] DC_ENABLE_O,
    input wire logic [DC_LEVEL_W-1:0] DC_LEVEL_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);
    // bus handshake: one wait-free access cycle
    a_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("ready missing after setup");
    a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_miss_error: assert property (PSEL_I && !PENABLE_I && PADDR_I != LEAD_OFF_CONTROL_ADDR
        |=> PSLVERR_O)
        else $error("unmapped address not flagged");
    a_miss_reads_zero: assert property (PSLVERR_O |-> PRDATA_O == 32'h0)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (PREADY_O && !PWRITE_I
        |-> (PRDATA_O & 32'hFF000E60) == 32'h0)
        else $error("reserved bits read nonzero");
    // dc detection is all electrodes at once, level only while active
    a_dc_all_or_none: assert property (DC_ENABLE_O != 6'h0 |-> DC_ENABLE_O == 6'h3F)
        else $error("partial dc enable");
    a_dc_level_idle: assert property (DC_ENABLE_O == 6'h0 |-> DC_LEVEL_O == 3'h0)
        else $error("dc level while dc off");
    // input is synchronised, so allow the three-edge lag before checking
    a_cal_forces_off: assert property (CAL_DAC_ON_I [*6] |-> AC_ENABLE_O == 6'h0)
        else $error("ac on during calibration");
    c_miss: cover property (PSLVERR_O);
    c_dc_on: cover property (DC_ENABLE_O == 6'h3F);
    c_ac_global: cover property (AC_ENABLE_O[5:1] == 5'h1F);
endmodule

// ==== verif/lead_off_detect_control_tb_top.sv ====
`timescale 1ns/1ps
module lead_off_detect_control_tb_top;
    import lead_off_pkg::*;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, cal = 0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwd = 32'h0, prd, w;
    logic pready, perr;
    logic [5:0] ac_en, ac_ph, dc_en;
    logic [1:0] ac_lv;
    logic [2:0] dc_lv;
    logic [23:0] r;
    logic [32:0] exp_q[$];
    int failures = 0, check_count = 0, seed = 7165;
    always #5 clk = ~clk;
    lead_off_detect_control uut(.CLK_SYS_I(clk), .RESETN_I(rstn), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PSTRB_I(4'hF),
        .CAL_DAC_ON_I(cal), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr),
        .AC_ENABLE_O(ac_en), .AC_PHASE_O(ac_ph), .DC_ENABLE_O(dc_en), .AC_LEVEL_O(ac_lv),
        .DC_LEVEL_O(dc_lv));
    task automatic cmp(input logic [32:0] e, input logic [32:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %0t exp %h got %h", $time, e, g);
        end
    endtask
    task print_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // psel stays high between calls so back-to-back transfers need no release
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] e);
        if (!wr) exp_q.push_back(e);
        psel <= 1; pen <= 0; pwr <= wr; paddr <= a; pwd <= d;
        @(posedge clk) pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
    endtask
    // expected pins: phase, ac, dc, ac level, dc level
    function automatic logic [32:0] outs(input logic [23:0] x, input logic c);
        logic dc;
        dc = x[0] & !x[1];
        return {10'h0, x[23:18], (x[17:12] | {{5{x[1]}}, 1'b0}) & {6{x[0] & !c}},
            {6{dc}}, x[8:7], x[4:2] & {3{dc}}};
    endfunction
    // read answers are taken off the queue as they appear
    always @(posedge clk) if (pready === 1'b1 && !pwr) cmp(exp_q.pop_front(), {perr, prd});
    initial begin
        #50us failures++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        apb(0, LEAD_OFF_CONTROL_ADDR, 32'h0, 33'h0);
        for (int i = 0; i < 40; i++) begin
            w = $random(seed);
            r = w[23:0] & WRITE_MASK;
            cal <= (i % 4 == 3);
            apb(1, LEAD_OFF_CONTROL_ADDR, w, 33'h0);
            apb(1, 8'h0C, ~w, 33'h0);
            apb(0, 8'h0C, 32'h0, {1'b1, 32'h0});
            apb(0, LEAD_OFF_CONTROL_ADDR, 32'h0, {9'h0, r});
            psel <= 0;
            pen <= 0;
            repeat (6) @(posedge clk);
            cmp(outs(r, cal), {10'h0, ac_ph, ac_en, dc_en, ac_lv, dc_lv});
        end
        print_verdict();
    end
endmodule
bind lead_off_detect_control lead_off_chk chk(.*);
